// ==== rtl/cgspr_top.sv ====
// two-channel 24-bit up/down, quadrature and period/rate counter
// assumes asynchronous a, b and gate pins; config and control words from a controller
// Functional notes
// - encoder counts step on leading edge of a; b picks up or down.
// - preset value 0..16777215 is loaded into count by preset-load bit.
// - reaching the rollover value wraps count to zero and counting continues.
// - rollover value ranges from 1 to 16777216.
// - counts are modulo rollover; 359 to 0 up, 0 to 359 down.
// - reset-count bits 0 and 4 of control word zero clear the counter.
// - gate pulses go through a power-of-two divider, 1 to 128.
// - stored count has its own word, replaced only on next gate trigger.
// - store mode 1 captures count, counting continues.
// - store mode 2 captures count, holds while gate high, resumes low.
// - store mode 3 captures, clears, holds while high, restarts on falling edge.
// - store mode 4 captures and clears; counting continues while gate high.
// - gate invert makes store and period functions use the falling edge.
// - period mode counts 5 MHz reference pulses across the divided gate.
// - frequency result in words 4/5 of each channel's read words.
// - pulse total in words 6/7 of each channel's read words.
// - each channel mode comes from the mode field of its own config entry.
// - all gate pulses are totalled; total-clear bit resets the total.
// - reference count per half gate cycle is 5 MHz over twice gate rate.
// - period mode ignores a and b; only the gate input measures.
// - counter mode: a pulses, b high counts down, low counts up.
// - x2 counts both a edges; x4 counts both edges of a and b.
`timescale 1ns/1ps
`default_nettype none
module cgspr_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // input pins per channel
    input wire logic [1:0] phase_a,
    input wire logic [1:0] phase_b,
    input wire logic [1:0] gate_in,
    // configuration and control
    input wire cgspr_pkg::cgspr_cfg_t [1:0] cfg,
    input wire logic [15:0] count_ctrl,
    // read words per channel
    output logic [1:0] [127:0] rd_words,
    output logic [1:0] zero_freq
);

    cgspr_pkg::cgspr_top_state_t st;
    cgspr_pkg::cgspr_top_state_t next_st;

    logic [5:0] pins_f;
    logic [1:0] a_f;
    logic [1:0] b_f;
    logic [1:0] g_f;
    logic [1:0] g_act;
    logic [1:0] sg;
    logic [1:0] rst_cnt;
    logic [1:0] pre_load;
    logic [1:0] pulse_total_clear;
    logic [1:0] do_up;
    logic [1:0] do_down;
    logic [1:0] cap;
    logic [1:0] hold;
    logic [1:0] sg_fall;
    logic ref_tick;
    logic [cgspr_pkg::CNT_W-1:0] rollm1 [2];

    cgspr_sync #(
        .W(6)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din({gate_in, phase_b, phase_a}),
        .dout(pins_f)
    );

    assign a_f = pins_f[1:0];
    assign b_f = pins_f[3:2];
    assign g_f = pins_f[5:4];

    // control word bits
    assign rst_cnt[0] = count_ctrl[cgspr_pkg::RESET_COUNT_BIT0];
    assign rst_cnt[1] = count_ctrl[cgspr_pkg::RESET_COUNT_BIT1];
    assign pre_load[0] = count_ctrl[cgspr_pkg::PRESET_LOAD_BIT0];
    assign pre_load[1] = count_ctrl[cgspr_pkg::PRESET_LOAD_BIT1];
    assign pulse_total_clear[0] = count_ctrl[cgspr_pkg::TOTAL_CLEAR_BIT0];
    assign pulse_total_clear[1] = count_ctrl[cgspr_pkg::TOTAL_CLEAR_BIT1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            // inverted gate feeds both divider and total
            assign g_act[gi] = g_f[gi] ^ cfg[gi].gate_invert;
            cgspr_prescale u_scale (
                .clk(clk),
                .reset(reset),
                .gate(g_act[gi]),
                .scale_sel(cfg[gi].scale_sel),
                .scaled(sg[gi])
            );
        end
    endgenerate

    assign ref_tick = (st.ref_div == cgspr_pkg::REF_DIV_LAST);

    always_comb begin
        logic step;
        logic up;
        logic a_edge;
        logic b_edge;
        logic sg_rise;
        logic clr;
        logic per;
        next_st = st;
        step = 1'b0;
        up = 1'b0;
        a_edge = 1'b0;
        b_edge = 1'b0;
        sg_rise = 1'b0;
        clr = 1'b0;
        per = 1'b0;
        do_up = 2'b00;
        do_down = 2'b00;
        cap = 2'b00;
        hold = 2'b00;
        sg_fall = 2'b00;
        next_st.ref_div = ref_tick ? 2'h0 : st.ref_div + 2'h1;
        for (int i = 0; i < 2; i++) begin
            rollm1[i] = cgspr_pkg::CNT_W'(cfg[i].rollover - 25'h000_0001);
            a_edge = a_f[i] ^ st.ch[i].a_prev;
            b_edge = b_f[i] ^ st.ch[i].b_prev;
            sg_rise = sg[i] & ~st.ch[i].sg_prev;
            sg_fall[i] = ~sg[i] & st.ch[i].sg_prev;
            per = (cfg[i].mode == cgspr_pkg::CGSPR_MODE_PERIOD);
            next_st.ch[i].a_prev = a_f[i];
            next_st.ch[i].b_prev = b_f[i];
            next_st.ch[i].sg_prev = sg[i];
            next_st.ch[i].g_prev = g_act[i];
            // step source and direction per mode
            case (cfg[i].mode)
                cgspr_pkg::CGSPR_MODE_COUNTER: begin
                    step = a_f[i] & ~st.ch[i].a_prev;
                    up = ~b_f[i];
                end
                cgspr_pkg::CGSPR_MODE_X1: begin
                    step = a_f[i] & ~st.ch[i].a_prev;
                    up = ~b_f[i];
                end
                cgspr_pkg::CGSPR_MODE_X2: begin
                    step = a_edge;
                    up = ~b_f[i];
                end
                cgspr_pkg::CGSPR_MODE_X4: begin
                    // simultaneous edges on both phases are invalid, dropped
                    step = a_edge ^ b_edge;
                    up = a_f[i] ^ st.ch[i].b_prev;
                end
                default: begin
                    step = 1'b0;
                    up = 1'b0;
                end
            endcase
            cap[i] = sg_rise & ~per & (cfg[i].store != cgspr_pkg::CGSPR_STORE_OFF);
            clr = cap[i] & ((cfg[i].store == cgspr_pkg::CGSPR_STORE_RST_WAIT) ||
                (cfg[i].store == cgspr_pkg::CGSPR_STORE_RST_START));
            hold[i] = sg[i] & ~per & ((cfg[i].store == cgspr_pkg::CGSPR_STORE_WAIT) ||
                (cfg[i].store == cgspr_pkg::CGSPR_STORE_RST_WAIT));
            if (cap[i]) begin
                next_st.ch[i].stored = st.ch[i].count;
            end
            do_up[i] = step & up & ~hold[i] & ~clr & ~rst_cnt[i] & ~pre_load[i];
            do_down[i] = step & ~up & ~hold[i] & ~clr & ~rst_cnt[i] & ~pre_load[i];
            if (rst_cnt[i]) begin
                next_st.ch[i].count = cgspr_pkg::CNT_RESET;
            end else if (pre_load[i]) begin
                next_st.ch[i].count = cfg[i].preset;
            end else if (clr) begin
                next_st.ch[i].count = cgspr_pkg::CNT_RESET;
            end else if (do_up[i]) begin
                if (st.ch[i].count >= rollm1[i]) begin
                    next_st.ch[i].count = cgspr_pkg::CNT_RESET;
                end else begin
                    next_st.ch[i].count = st.ch[i].count + 24'h00_0001;
                end
            end else if (do_down[i]) begin
                if ((st.ch[i].count == cgspr_pkg::CNT_RESET) ||
                    (st.ch[i].count > rollm1[i])) begin
                    next_st.ch[i].count = rollm1[i];
                end else begin
                    next_st.ch[i].count = st.ch[i].count - 24'h00_0001;
                end
            end
            // running total of every active gate edge
            if (pulse_total_clear[i]) begin
                next_st.ch[i].total = cgspr_pkg::CNT_RESET;
            end else if (g_act[i] && !st.ch[i].g_prev) begin
                next_st.ch[i].total = st.ch[i].total + 24'h00_0001;
            end
            // reference pulses across the active half of the divided gate
            if (per) begin
                if (sg_rise) begin
                    next_st.ch[i].ref_cnt = cgspr_pkg::REF_RESET;
                end else if (sg[i] && ref_tick && (st.ch[i].ref_cnt != cgspr_pkg::REF_MAX)) begin
                    next_st.ch[i].ref_cnt = st.ch[i].ref_cnt + 25'h000_0001;
                end
                if (sg[i] && (st.ch[i].ref_cnt == cgspr_pkg::REF_MAX)) begin
                    next_st.ch[i].freq = cgspr_pkg::REF_RESET;
                    next_st.ch[i].zero_freq = 1'b1;
                end else if (sg_fall[i]) begin
                    next_st.ch[i].freq = st.ch[i].ref_cnt;
                    next_st.ch[i].zero_freq = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // read words: count, stored, frequency, total, each low then high
    generate
        for (gi = 0; gi < 2; gi++) begin : g_rd
            assign rd_words[gi][15:0] = st.ch[gi].count[15:0];
            assign rd_words[gi][31:16] = {8'h00, st.ch[gi].count[23:16]};
            assign rd_words[gi][47:32] = st.ch[gi].stored[15:0];
            assign rd_words[gi][63:48] = {8'h00, st.ch[gi].stored[23:16]};
            assign rd_words[gi][79:64] = st.ch[gi].freq[15:0];
            assign rd_words[gi][95:80] = {7'h00, st.ch[gi].freq[24:16]};
            assign rd_words[gi][111:96] = st.ch[gi].total[15:0];
            assign rd_words[gi][127:112] = {8'h00, st.ch[gi].total[23:16]};
            assign zero_freq[gi] = st.ch[gi].zero_freq;

            property p_sw_reset;
                @(posedge clk) disable iff (reset)
                rst_cnt[gi] |=> (st.ch[gi].count == 24'h00_0000);
            endproperty
            a_sw_reset: assert property (p_sw_reset) else $error("count not cleared");

            property p_preset;
                @(posedge clk) disable iff (reset)
                (pre_load[gi] && !rst_cnt[gi]) |=> (st.ch[gi].count == $past(cfg[gi].preset));
            endproperty
            a_preset: assert property (p_preset) else $error("preset not loaded");

            property p_wrap_up;
                @(posedge clk) disable iff (reset)
                (do_up[gi] && (st.ch[gi].count == rollm1[gi])) |=>
                    (st.ch[gi].count == 24'h00_0000);
            endproperty
            a_wrap_up: assert property (p_wrap_up) else $error("no wrap to zero");

            property p_wrap_down;
                @(posedge clk) disable iff (reset)
                (do_down[gi] && (st.ch[gi].count == 24'h00_0000)) |=>
                    (st.ch[gi].count == $past(rollm1[gi]));
            endproperty
            a_wrap_down: assert property (p_wrap_down) else $error("no wrap down");

            property p_capture;
                @(posedge clk) disable iff (reset)
                cap[gi] |=> (st.ch[gi].stored == $past(st.ch[gi].count)) ##1
                    (st.ch[gi].stored == $past(st.ch[gi].stored)) || $past(cap[gi]);
            endproperty
            a_capture: assert property (p_capture) else $error("stored count wrong");

            property p_mode3;
                @(posedge clk) disable iff (reset)
                (cap[gi] && !rst_cnt[gi] && !pre_load[gi] &&
                    (cfg[gi].store == cgspr_pkg::CGSPR_STORE_RST_WAIT)) |=>
                    (st.ch[gi].count == 24'h00_0000);
            endproperty
            a_mode3: assert property (p_mode3) else $error("mode 3 did not clear");

            property p_hold;
                @(posedge clk) disable iff (reset)
                (hold[gi] && !rst_cnt[gi] && !pre_load[gi] && !cap[gi]) |=>
                    $stable(st.ch[gi].count);
            endproperty
            a_hold: assert property (p_hold) else $error("count moved while held");

            property p_total_clear;
                @(posedge clk) disable iff (reset)
                pulse_total_clear[gi] |=> (st.ch[gi].total == 24'h00_0000);
            endproperty
            a_total_clear: assert property (p_total_clear) else $error("total not cleared");

            property p_period_ignore;
                @(posedge clk) disable iff (reset)
                ((cfg[gi].mode == cgspr_pkg::CGSPR_MODE_PERIOD) && !rst_cnt[gi] &&
                    !pre_load[gi]) |=> $stable(st.ch[gi].count);
            endproperty
            a_period_ignore: assert property (p_period_ignore) else $error("a/b counted");

            property p_freq;
                @(posedge clk) disable iff (reset)
                ((cfg[gi].mode == cgspr_pkg::CGSPR_MODE_PERIOD) && sg_fall[gi] &&
                    (st.ch[gi].ref_cnt != cgspr_pkg::REF_MAX)) |=>
                    (st.ch[gi].freq == $past(st.ch[gi].ref_cnt)) && !st.ch[gi].zero_freq;
            endproperty
            a_freq: assert property (p_freq) else $error("frequency not reported");

            property p_mode4;
                @(posedge clk) disable iff (reset)
                (cap[gi] && !rst_cnt[gi] && !pre_load[gi] &&
                    (cfg[gi].store == cgspr_pkg::CGSPR_STORE_RST_START)) |=>
                    (st.ch[gi].count == 24'h00_0000);
            endproperty
            a_mode4: assert property (p_mode4) else $error("mode 4 did not clear");

            property p_step_up;
                @(posedge clk) disable iff (reset)
                (do_up[gi] && (st.ch[gi].count < rollm1[gi])) |=>
                    (st.ch[gi].count == $past(st.ch[gi].count) + 24'h00_0001);
            endproperty
            a_step_up: assert property (p_step_up) else $error("count did not step up");

            property p_total_step;
                @(posedge clk) disable iff (reset)
                (!pulse_total_clear[gi] && g_act[gi] && !st.ch[gi].g_prev) |=>
                    (st.ch[gi].total == $past(st.ch[gi].total) + 24'h00_0001);
            endproperty
            a_total_step: assert property (p_total_step) else $error("edge not totalled");

            c_wrap: cover property (@(posedge clk) disable iff (reset)
                do_up[gi] && (st.ch[gi].count == rollm1[gi]));
            c_capture: cover property (@(posedge clk) disable iff (reset) cap[gi]);
            c_freq: cover property (@(posedge clk) disable iff (reset)
                (cfg[gi].mode == cgspr_pkg::CGSPR_MODE_PERIOD) && sg_fall[gi]);
            c_hold: cover property (@(posedge clk) disable iff (reset) hold[gi]);
            c_quad: cover property (@(posedge clk) disable iff (reset)
                (cfg[gi].mode == cgspr_pkg::CGSPR_MODE_X4) && do_down[gi]);
        end
    endgenerate

endmodule
`default_nettype wire

// ==== rtl/cgspr_pkg.sv ====
// constants, modes and carrier types of the two-channel gate/store counter
// assumes a single 20 MHz clock; shared by the cgspr_top and cgspr_prescale design files
package cgspr_pkg;

    localparam int NUM_CH = 2;
    localparam int CNT_W = 24;
    localparam int ROLL_W = 25;
    localparam int REF_W = 25;
    localparam int WORD_W = 16;
    localparam int SCALE_W = 7;

    // clock and reference timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned REF_HZ = 5_000_000;
    localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
    localparam logic [1:0] REF_DIV_LAST = 2'(REF_DIV - 1);
    // 6.71 s of 5 MHz reference fills the reference counter
    localparam logic [REF_W-1:0] REF_MAX = 25'h1ff_ffff;

    // control word 0 bit positions
    localparam int RESET_COUNT_BIT0 = 0;
    localparam int RESET_COUNT_BIT1 = 4;
    localparam int PRESET_LOAD_BIT0 = 1;
    localparam int PRESET_LOAD_BIT1 = 5;
    localparam int TOTAL_CLEAR_BIT0 = 2;
    localparam int TOTAL_CLEAR_BIT1 = 6;

    // reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
    localparam logic [REF_W-1:0] REF_RESET = 25'h000_0000;
    localparam logic [SCALE_W-1:0] SCALE_RESET = 7'h00;

    typedef enum logic [4:0] {
        CGSPR_MODE_COUNTER = 5'h01,
        CGSPR_MODE_X1 = 5'h02,
        CGSPR_MODE_X2 = 5'h04,
        CGSPR_MODE_X4 = 5'h08,
        CGSPR_MODE_PERIOD = 5'h10
    } cgspr_mode_t;

    typedef enum logic [4:0] {
        CGSPR_STORE_OFF = 5'h01,
        CGSPR_STORE_CONT = 5'h02,
        CGSPR_STORE_WAIT = 5'h04,
        CGSPR_STORE_RST_WAIT = 5'h08,
        CGSPR_STORE_RST_START = 5'h10
    } cgspr_store_t;

    typedef struct packed {
        cgspr_mode_t mode;
        cgspr_store_t store;
        logic gate_invert;
        logic [2:0] scale_sel;
        logic [CNT_W-1:0] preset;
        logic [ROLL_W-1:0] rollover;
    } cgspr_cfg_t;

    typedef struct packed {
        logic [WORD_W-1:0] high_word;
        logic [WORD_W-1:0] low_word;
    } cgspr_word_pair_t;

    typedef struct packed {
        cgspr_word_pair_t count;
        cgspr_word_pair_t stored;
        cgspr_word_pair_t freq;
        cgspr_word_pair_t total;
        logic zero_freq;
    } cgspr_read_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] stored;
        logic [CNT_W-1:0] total;
        logic [REF_W-1:0] ref_cnt;
        logic [REF_W-1:0] freq;
        logic zero_freq;
        logic a_prev;
        logic b_prev;
        logic sg_prev;
        logic g_prev;
    } cgspr_chan_t;

    typedef struct packed {
        cgspr_chan_t [NUM_CH-1:0] ch;
        logic [1:0] ref_div;
    } cgspr_top_state_t;

    typedef struct packed {
        logic g_prev;
        logic [SCALE_W-1:0] cnt;
        logic out;
    } cgspr_scale_state_t;

endpackage

// ==== rtl/cgspr_sync.sv ====
// three-stage input synchroniser with agreement filter, W bits wide
// assumes asynchronous pins; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cgspr_sync #(
    parameter int W = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins and filtered levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } cgspr_sync_state_t;

    cgspr_sync_state_t st;
    cgspr_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.lvl;

endmodule
`default_nettype wire

// ==== rtl/cgspr_prescale.sv ====
// power-of-two divider of one gate level, divide by 1 to 128
// assumes a filtered, already inverted gate level on the same clock
`timescale 1ns/1ps
`default_nettype none
module cgspr_prescale (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // gate level and divider select
    input wire logic gate,
    input wire logic [2:0] scale_sel,
    // divided gate level
    output logic scaled
);

    cgspr_pkg::cgspr_scale_state_t st;
    cgspr_pkg::cgspr_scale_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.g_prev = gate;
        // one step per active gate edge, divided level taken from a counter bit
        if (gate && !st.g_prev) begin
            next_st.cnt = st.cnt + 7'h01;
        end
        if (scale_sel == 3'h0) begin
            next_st.out = gate;
        end else begin
            next_st.out = next_st.cnt[scale_sel - 3'h1];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign scaled = st.out;

    property p_div_one;
        @(posedge clk) disable iff (reset)
        (scale_sel == 3'h0) |=> (scaled == $past(gate));
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one lost the gate");

endmodule
`default_nettype wire

// ==== verif/cgspr_pins_model.sv ====
// pin-side model: encoder, pulse source and gate switch on a, b, gate pins
// assumes the bench calls its tasks; levels change at falling clock edges
`timescale 1ns/1ps
`default_nettype none
module cgspr_pins_model (
    // clock
    input wire logic clk,
    // pins toward the counter
    output logic [1:0] phase_a,
    output logic [1:0] phase_b,
    output logic [1:0] gate_in
);
    initial begin
        phase_a = 2'h0;
        phase_b = 2'h0;
        gate_in = 2'h0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // levels kept well beyond the synchroniser filter
    task automatic pulse_a(input int ch, input int n);
        repeat (n) begin
            phase_a[ch] = 1'b1;
            hold(8);
            phase_a[ch] = 1'b0;
            hold(8);
        end
    endtask

    task automatic set_b(input int ch, input logic v);
        phase_b[ch] = v;
        hold(10);
    endtask

    task automatic set_gate(input int ch, input logic v);
        gate_in[ch] = v;
        hold(10);
    endtask

    // gate period far below the reference overflow limit
    task automatic pulse_gate(input int ch, input int half);
        gate_in[ch] = 1'b1;
        hold(half);
        gate_in[ch] = 1'b0;
        hold(half);
    endtask

    // quadrature steps, a leads b unless rev
    task automatic quad(input int ch, input int n, input logic rev);
        repeat (n) begin
            for (int k = 0; k < 4; k++) begin
                if (k[0] ^ rev) begin
                    phase_b[ch] = (k < 2);
                end else begin
                    phase_a[ch] = (k < 2);
                end
                hold(6);
            end
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/cgspr_top_tb_top.sv ====
// self-checking bench of the two-channel gate/store counter
// assumes cgspr_pkg compiled first; pins come from cgspr_pins_model
`timescale 1ns/1ps
`default_nettype none
module cgspr_top_tb_top;
    typedef struct {int ch; int idx; logic [15:0] exp; int tol;} cgspr_note_t;
    logic clk;
    logic reset;
    wire logic [1:0] phase_a;
    wire logic [1:0] phase_b;
    wire logic [1:0] gate_in;
    cgspr_pkg::cgspr_cfg_t [1:0] cfg;
    logic [15:0] count_ctrl;
    logic [1:0] [127:0] rd_words;
    logic [1:0] zero_freq;
    int err_total = 0;
    int num_checks = 0;
    cgspr_note_t notes[$];
    cgspr_note_t n;
    event chk_ev;
    logic [23:0] r;
    cgspr_pkg::cgspr_store_t modes[4];
    logic [15:0] cnt_exp[4];

    cgspr_top DUT (.clk(clk), .reset(reset), .phase_a(phase_a), .phase_b(phase_b),
        .gate_in(gate_in), .cfg(cfg), .count_ctrl(count_ctrl), .rd_words(rd_words),
        .zero_freq(zero_freq));
    cgspr_pins_model pins (.clk(clk), .phase_a(phase_a), .phase_b(phase_b), .gate_in(gate_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int tol);
        logic near;
        num_checks++;
        near = !$isunknown(seen) && (tol > 0) && (seen + tol >= exp) && (seen <= exp + tol);
        if (seen !== exp && !near) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic void note(int ch, int idx, logic [15:0] exp, int tol);
        notes.push_back('{ch, idx, exp, tol});
    endfunction

    task automatic sample();
        -> chk_ev;
        @(negedge clk);
    endtask

    // watcher: compares each noted expectation with the read words
    always begin
        @(chk_ev);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            // word index 8 selects the zero-frequency flag
            if (n.idx == 8) begin
                check({15'h0000, zero_freq[n.ch]}, n.exp, n.tol);
            end else begin
                check(rd_words[n.ch][n.idx*16 +: 16], n.exp, n.tol);
            end
        end
    end

    task automatic ctl(input logic [15:0] bits);
        @(negedge clk);
        count_ctrl = bits;
        @(negedge clk);
        count_ctrl = 16'h0000;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("Error at %0t: run limit reached", $time);
        give_verdict();
    end

    initial begin
        reset = 1'b1;
        count_ctrl = 16'h0000;
        cfg[0] = '{mode: cgspr_pkg::CGSPR_MODE_COUNTER, store: cgspr_pkg::CGSPR_STORE_OFF,
            gate_invert: 1'b0, scale_sel: 3'h0, preset: 24'h00_0000, rollover: 25'h100_0000};
        cfg[1] = cfg[0];
        cfg[1].mode = cgspr_pkg::CGSPR_MODE_X2;
        modes = '{cgspr_pkg::CGSPR_STORE_CONT, cgspr_pkg::CGSPR_STORE_WAIT,
            cgspr_pkg::CGSPR_STORE_RST_WAIT, cgspr_pkg::CGSPR_STORE_RST_START};
        cnt_exp = '{16'h0004, 16'h0003, 16'h0000, 16'h0001};
        void'($urandom(66174));
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        // direction by b level, x2 on both a edges
        pins.pulse_a(0, 3);
        pins.set_b(0, 1'b1);
        pins.pulse_a(0, 1);
        pins.pulse_a(1, 2);
        note(0, 0, 16'h0002, 0);
        note(1, 0, 16'h0004, 0);
        sample();
        cfg[1].mode = cgspr_pkg::CGSPR_MODE_X1;
        pins.pulse_a(1, 2);
        note(1, 0, 16'h0006, 0);
        sample();
        cfg[1].mode = cgspr_pkg::CGSPR_MODE_X4;
        pins.quad(1, 2, 1'b0);
        pins.quad(1, 1, 1'b1);
        note(1, 0, 16'h000a, 0);
        sample();
        $display("test direction done");
        // preset, circular rollover and software reset
        cfg[0].rollover = 25'h000_0168;
        cfg[0].preset = 24'h00_0167;
        ctl(16'h0001);
        ctl(16'h0002);
        note(0, 0, 16'h0167, 0);
        sample();
        pins.set_b(0, 1'b0);
        pins.pulse_a(0, 1);
        note(0, 0, 16'h0000, 0);
        sample();
        pins.set_b(0, 1'b1);
        pins.pulse_a(0, 1);
        note(0, 0, 16'h0167, 0);
        sample();
        r = 24'($urandom);
        cfg[1].preset = r;
        ctl(16'h0020);
        note(1, 0, r[15:0], 0);
        note(1, 1, {8'h00, r[23:16]}, 0);
        sample();
        ctl(16'h0011);
        note(0, 0, 16'h0000, 0);
        note(1, 0, 16'h0000, 0);
        note(1, 1, 16'h0000, 0);
        sample();
        $display("test rollover done");
        // four store behaviours, one a pulse while the gate is high
        cfg[0].rollover = 25'h100_0000;
        pins.set_b(0, 1'b0);
        for (int m = 0; m < 4; m++) begin
            cfg[0].store = modes[m];
            ctl(16'h0001);
            pins.pulse_a(0, 3);
            pins.set_gate(0, 1'b1);
            pins.pulse_a(0, 1);
            pins.set_gate(0, 1'b0);
            note(0, 2, 16'h0003, 0);
            note(0, 0, cnt_exp[m], 0);
            sample();
        end
        // falling-edge capture with the gate inverted
        cfg[0].store = cgspr_pkg::CGSPR_STORE_OFF;
        pins.set_gate(0, 1'b1);
        cfg[0].store = cgspr_pkg::CGSPR_STORE_CONT;
        cfg[0].gate_invert = 1'b1;
        pins.pulse_a(0, 2);
        pins.set_gate(0, 1'b0);
        note(0, 2, 16'h0003, 0);
        sample();
        $display("test store done");
        // period measurement with a divide-by-two scaler
        cfg[0] = '{mode: cgspr_pkg::CGSPR_MODE_PERIOD, store: cgspr_pkg::CGSPR_STORE_OFF,
            gate_invert: 1'b0, scale_sel: 3'h1, preset: 24'h00_0000, rollover: 25'h100_0000};
        pins.hold(10);
        ctl(16'h0004);
        repeat (4) pins.pulse_gate(0, 200);
        pins.pulse_a(0, 2);
        note(0, 4, 16'h0064, 2);
        note(0, 5, 16'h0000, 0);
        note(0, 6, 16'h0004, 0);
        note(0, 7, 16'h0000, 0);
        note(0, 0, 16'h0003, 0);
        note(0, 8, 16'h0000, 0);
        sample();
        $display("test period done");
        give_verdict();
    end
endmodule
`default_nettype wire
